// *** core/ucs_regs.vh ***
// Constants for the user counter views and machine status CSR block.
// Assumes a core that issues one CSR access per cycle on the core clock.
`ifndef UCS_REGS_VH
`define UCS_REGS_VH

`define UCS_ADDR_TABLE_JUMP 12'h017
`define UCS_ADDR_STATUS 12'h300
`define UCS_ADDR_CYCLE_LO 12'hc00
`define UCS_ADDR_RETIRED_LO 12'hc02
`define UCS_ADDR_PERF_LO_FIRST 12'hc03
`define UCS_ADDR_PERF_LO_LAST 12'hc1f
`define UCS_ADDR_CYCLE_HI 12'hc80
`define UCS_ADDR_RETIRED_HI 12'hc82
`define UCS_ADDR_PERF_HI_FIRST 12'hc83
`define UCS_ADDR_PERF_HI_LAST 12'hc9f

`define UCS_TJ_BASE_MSB 31
`define UCS_TJ_BASE_LSB 6
`define UCS_TJ_RESET 32'h0000_0000

`define UCS_ST_DIRTY 31
`define UCS_ST_OTH_MSB 16
`define UCS_ST_OTH_LSB 15
`define UCS_ST_FLT_MSB 14
`define UCS_ST_FLT_LSB 13
`define UCS_ST_PRV_MSB 12
`define UCS_ST_PRV_LSB 11
`define UCS_ST_VEC_MSB 10
`define UCS_ST_VEC_LSB 9
`define UCS_ST_PIE 7
`define UCS_ST_IE 3
`define UCS_CTX_DIRTY 2'h3
`define UCS_CTX_OFF 2'h0
`define UCS_PRIV_MACHINE 2'h3

`define UCS_OP_WRITE 2'h1
`define UCS_OP_SET 2'h2
`define UCS_OP_CLEAR 2'h3

`endif

// *** core/ucs_wdata.v ***
// Computes the new CSR value from the old value, operand and operation.
// Operation codes come from the core's CSR decoder.
`timescale 1ns/1ps
`include "ucs_regs.vh"
module ucs_wdata
(
    // Operands
    input wire [1:0] op,
    input wire [31:0] old_value,
    input wire [31:0] operand,
    // Result
    output reg [31:0] new_value
);
    always @*
    begin
        case (op)
            `UCS_OP_WRITE: new_value = operand;
            `UCS_OP_SET: new_value = old_value | operand;
            `UCS_OP_CLEAR: new_value = old_value & ~operand;
            default: new_value = old_value;
        endcase
    end
endmodule

// *** core/ucs_decode.v ***
// Address decode for the CSRs held or viewed by this block.
// Legality depends on the address and options only, never on field types.
`timescale 1ns/1ps
`include "ucs_regs.vh"
module ucs_decode
#(
    parameter COMPRESSED_EXT_PARAM = 1
)
(
    // Address
    input wire [11:0] addr,
    // Decode
    output wire hit_table_jump,
    output wire hit_status,
    output wire hit_counter,
    output wire read_only,
    output wire legal
);
    assign hit_table_jump = (COMPRESSED_EXT_PARAM == 1) &&
        (addr == `UCS_ADDR_TABLE_JUMP);
    assign hit_status = (addr == `UCS_ADDR_STATUS);
    assign hit_counter = (addr == `UCS_ADDR_CYCLE_LO) ||
        (addr == `UCS_ADDR_RETIRED_LO) ||
        (addr == `UCS_ADDR_CYCLE_HI) ||
        (addr == `UCS_ADDR_RETIRED_HI) ||
        ((addr >= `UCS_ADDR_PERF_LO_FIRST) &&
         (addr <= `UCS_ADDR_PERF_LO_LAST)) ||
        ((addr >= `UCS_ADDR_PERF_HI_FIRST) &&
         (addr <= `UCS_ADDR_PERF_HI_LAST));
    assign read_only = hit_counter;
    assign legal = hit_table_jump || hit_status || hit_counter;
endmodule

// *** core/ucs_csr.v ***
// CSR bank: user counter views, table-jump base and machine status.
// Counters are kept elsewhere in the core and arrive as plain inputs.
// Accesses arrive as one-cycle requests from logic on the same clock.
`timescale 1ns/1ps
`include "ucs_regs.vh"
module ucs_csr
#(
    parameter COMPRESSED_EXT_PARAM = 1,
    parameter EXT_IF_PARAM = 1,
    parameter [1:0] OTHER_EXT_STATUS_RESET_PARAM = 2'h0
)
(
    // Clock and reset
    input wire clk,
    input wire resetn,
    // CSR access from the core
    input wire csr_req,
    input wire [11:0] csr_addr,
    input wire [1:0] csr_op,
    input wire [31:0] csr_operand,
    // Trap sequencing
    input wire trap_enter,
    input wire machine_return,
    // Counter values from the core
    input wire [63:0] cycle_count,
    input wire [63:0] retired_count,
    input wire [29*64-1:0] perf_counts,
    // Access answer
    output reg csr_valid,
    output reg [31:0] csr_rdata,
    output reg csr_illegal,
    // Status towards the core
    output reg global_int_enable,
    output reg [31:0] table_jump_base
);
    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire hit_tj;
    wire hit_st;
    wire hit_cnt;
    wire ro;
    wire legal;
    reg [31:0] old_value;
    wire [31:0] new_value;
    reg [1:0] float_cs_reg;
    reg [1:0] vector_cs_reg;
    reg [1:0] other_cs_reg;
    reg pie_reg;
    reg ie_reg;
    reg [25:0] tj_reg;
    reg [31:0] status_view;
    reg [31:0] counter_view;
    reg [4:0] perf_idx;
    wire write_ok;
    wire is_write;

    ucs_decode #(
        .COMPRESSED_EXT_PARAM(COMPRESSED_EXT_PARAM)
    ) u_decode (
        .addr(csr_addr),
        .hit_table_jump(hit_tj),
        .hit_status(hit_st),
        .hit_counter(hit_cnt),
        .read_only(ro),
        .legal(legal)
    );

    ucs_wdata u_wdata (
        .op(csr_op),
        .old_value(old_value),
        .operand(csr_operand),
        .new_value(new_value)
    );

    // Set or clear with a zero operand is a pure read, so a read-only
    // counter must not fault on it.
    assign is_write = (csr_op == `UCS_OP_WRITE) ||
        (csr_operand != 32'h0000_0000);
    assign write_ok = csr_req && legal && !(ro && is_write) &&
        (csr_op != 2'h0);

    // ----------------------------------------------------------------
    // Read views
    // ----------------------------------------------------------------
    always @*
    begin
        status_view = 32'h0000_0000;
        status_view[`UCS_ST_DIRTY] = (float_cs_reg == `UCS_CTX_DIRTY) ||
            (other_cs_reg == `UCS_CTX_DIRTY) ||
            (vector_cs_reg == `UCS_CTX_DIRTY);
        status_view[`UCS_ST_OTH_MSB:`UCS_ST_OTH_LSB] = other_cs_reg;
        status_view[`UCS_ST_FLT_MSB:`UCS_ST_FLT_LSB] = float_cs_reg;
        status_view[`UCS_ST_PRV_MSB:`UCS_ST_PRV_LSB] =
            `UCS_PRIV_MACHINE;
        status_view[`UCS_ST_VEC_MSB:`UCS_ST_VEC_LSB] = vector_cs_reg;
        status_view[`UCS_ST_PIE] = pie_reg;
        status_view[`UCS_ST_IE] = ie_reg;
    end

    always @*
    begin
        perf_idx = 5'h00;
        counter_view = 32'h0000_0000;
        if ((csr_addr >= `UCS_ADDR_PERF_LO_FIRST) &&
            (csr_addr <= `UCS_ADDR_PERF_LO_LAST))
        begin
            perf_idx = csr_addr[4:0] - 5'h03;
            counter_view = perf_counts[perf_idx*64 +: 32];
        end
        else if ((csr_addr >= `UCS_ADDR_PERF_HI_FIRST) &&
            (csr_addr <= `UCS_ADDR_PERF_HI_LAST))
        begin
            perf_idx = csr_addr[4:0] - 5'h03;
            counter_view = perf_counts[perf_idx*64+32 +: 32];
        end
        else if (csr_addr == `UCS_ADDR_CYCLE_LO)
            counter_view = cycle_count[31:0];
        else if (csr_addr == `UCS_ADDR_RETIRED_LO)
            counter_view = retired_count[31:0];
        else if (csr_addr == `UCS_ADDR_CYCLE_HI)
            counter_view = cycle_count[63:32];
        else if (csr_addr == `UCS_ADDR_RETIRED_HI)
            counter_view = retired_count[63:32];
    end

    always @*
    begin
        old_value = 32'h0000_0000;
        if (hit_tj)
            old_value = {tj_reg, 6'h00};
        else if (hit_st)
            old_value = status_view;
        else if (hit_cnt)
            old_value = counter_view;
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tj_reg <= 26'h000_0000;
            float_cs_reg <= `UCS_CTX_OFF;
            vector_cs_reg <= `UCS_CTX_OFF;
            // Software never writes this field, so the parameter
            // value is loaded by reset and nowhere else.
            other_cs_reg <= (EXT_IF_PARAM == 1) ?
                OTHER_EXT_STATUS_RESET_PARAM : `UCS_CTX_OFF;
            pie_reg <= 1'b0;
            ie_reg <= 1'b0;
        end
        else
        begin
            if (write_ok && hit_tj)
                tj_reg <= new_value[`UCS_TJ_BASE_MSB:`UCS_TJ_BASE_LSB];
            // Previous enable is read-only to software: only trap
            // entry loads it, a status write leaves it alone.
            if (trap_enter)
            begin
                pie_reg <= ie_reg;
                ie_reg <= 1'b0;
            end
            else if (machine_return)
                ie_reg <= pie_reg;
            else if (write_ok && hit_st)
                ie_reg <= new_value[`UCS_ST_IE];
            if (write_ok && hit_st && EXT_IF_PARAM == 1)
            begin
                float_cs_reg <=
                    new_value[`UCS_ST_FLT_MSB:`UCS_ST_FLT_LSB];
                vector_cs_reg <=
                    new_value[`UCS_ST_VEC_MSB:`UCS_ST_VEC_LSB];
            end
        end
    end

    // ----------------------------------------------------------------
    // Answer
    // ----------------------------------------------------------------
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            csr_valid <= 1'b0;
            csr_rdata <= 32'h0000_0000;
            csr_illegal <= 1'b0;
            global_int_enable <= 1'b0;
            table_jump_base <= `UCS_TJ_RESET;
        end
        else
        begin
            csr_valid <= csr_req;
            // A refused access returns zero, never a counter value.
            csr_rdata <= (csr_req && legal && !(ro && is_write)) ?
                old_value : 32'h0000_0000;
            // Read-only views fault on a real write; the counters
            // themselves never change here.
            csr_illegal <= csr_req && (!legal || (ro && is_write));
            global_int_enable <= ie_reg;
            table_jump_base <= {tj_reg, 6'h00};
        end
    end
endmodule

// *** tb/ucs_csr_props.sv ***
// Concurrent checks on the ports of the CSR bank.
// Assumes one core clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module ucs_csr_props
(
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Requests, trap events and cycle count
    input wire csr_req,
    input wire [11:0] csr_addr,
    input wire [1:0] csr_op,
    input wire [31:0] csr_operand,
    input wire trap_enter,
    input wire machine_return,
    input wire [63:0] cycle_count,
    // Answers
    input wire csr_valid,
    input wire [31:0] csr_rdata,
    input wire csr_illegal,
    input wire global_int_enable,
    input wire [31:0] table_jump_base
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire [31:0] cyc_lo = cycle_count[31:0];
    wire op_ie = csr_operand[3];
    wire st_req = csr_req && csr_addr == 12'h300;
    wire [7:0] lo = csr_addr[7:0];
    wire cnt_wr = csr_req && csr_op == 2'h1 && csr_addr[11:8] == 4'hc
        && (lo <= 8'h1f || (lo >= 8'h80 && lo <= 8'h9f));
    // ------------------------------------------
    // Access answers and interrupt enable
    // ------------------------------------------
    cycle_view_a: assert property (
        csr_req && csr_addr == 12'hc00 && csr_op == 2'h0 |=> csr_valid
        && !csr_illegal && csr_rdata == $past(cyc_lo))
        else $error("cycle view read wrong");
    counter_write_a: assert property (cnt_wr |=> csr_illegal)
        else $error("counter view write not refused");
    status_legal_a: assert property (st_req |=> csr_valid && !csr_illegal)
        else $error("status access refused");
    illegal_data_a: assert property (
        csr_illegal |-> csr_valid && csr_rdata == 32'h0)
        else $error("refused access returned data");
    status_fixed_a: assert property (
        st_req |=> csr_rdata[12:11] == 2'h3 && csr_rdata[30:17] == 14'h0
        && csr_rdata[8] == 1'h0 && csr_rdata[6:4] == 3'h0
        && csr_rdata[2:0] == 3'h0)
        else $error("status fixed fields wrong");
    dirty_bit_a: assert property (
        st_req |=> csr_rdata[31] == (&csr_rdata[16:15] || &csr_rdata[14:13]
        || &csr_rdata[10:9]))
        else $error("status dirty summary wrong");
    jump_mode_a: assert property (
        csr_req && csr_addr == 12'h017 |=> csr_rdata[5:0] == 6'h0
        && table_jump_base[5:0] == 6'h0)
        else $error("jump mode not zero");
    trap_clear_a: assert property (trap_enter |-> ##2 !global_int_enable)
        else $error("trap left enable set");
    return_restore_a: assert property (
        trap_enter ##1 (machine_return && !trap_enter && !csr_req)
        |-> ##2 global_int_enable == $past(global_int_enable, 2))
        else $error("return did not restore enable");
    ie_write_a: assert property (
        st_req && csr_op == 2'h1 && !trap_enter && !machine_return
        |-> ##2 global_int_enable == $past(op_ie, 2))
        else $error("enable write not seen");
endmodule

bind ucs_csr ucs_csr_props i_ucs_csr_props (.clk(clk), .resetn(resetn),
    .csr_req(csr_req), .csr_addr(csr_addr), .csr_op(csr_op),
    .csr_operand(csr_operand), .trap_enter(trap_enter),
    .machine_return(machine_return), .cycle_count(cycle_count),
    .csr_valid(csr_valid), .csr_rdata(csr_rdata), .csr_illegal(csr_illegal),
    .global_int_enable(global_int_enable), .table_jump_base(table_jump_base));

// *** tb/tb.sv ***
// Self-checking bench for the CSR bank.
// Drives every port itself; expectations come from local functions.
`timescale 1ns/1ps
module tb;
    localparam [1:0] EXT_STAT = 2'h1;
    reg clk = 1'h0;
    reg resetn = 1'h0;
    reg csr_req = 1'h0;
    reg [11:0] csr_addr = 12'h0;
    reg [1:0] csr_op = 2'h0;
    reg [31:0] csr_operand = 32'h0;
    reg trap_enter = 1'h0;
    reg machine_return = 1'h0;
    reg [63:0] cycle_count = 64'h0;
    reg [63:0] retired_count = 64'h0;
    reg [29*64-1:0] perf_counts = 1856'h0;
    wire csr_valid;
    wire [31:0] csr_rdata;
    wire csr_illegal;
    wire global_int_enable;
    wire [31:0] table_jump_base;
    integer num_errors = 0;
    integer check_count = 0;
    integer i;
    reg [31:0] st, tj, d;
    ucs_csr #(.COMPRESSED_EXT_PARAM(1), .EXT_IF_PARAM(1),
        .OTHER_EXT_STATUS_RESET_PARAM(EXT_STAT)) i_ucs_csr (.clk(clk),
        .resetn(resetn), .csr_req(csr_req), .csr_addr(csr_addr),
        .csr_op(csr_op), .csr_operand(csr_operand), .trap_enter(trap_enter),
        .machine_return(machine_return), .cycle_count(cycle_count),
        .retired_count(retired_count), .perf_counts(perf_counts),
        .csr_valid(csr_valid), .csr_rdata(csr_rdata),
        .csr_illegal(csr_illegal), .global_int_enable(global_int_enable),
        .table_jump_base(table_jump_base));
    always #20 clk = ~clk;
    // ------------------------------------------
    // Expectations and drivers
    // ------------------------------------------
    function [31:0] st_exp(input [31:0] v);
        begin
            st_exp = (v & 32'h0000_6688) | 32'h0000_1800
                | {15'h0, EXT_STAT, 15'h0};
            st_exp[31] = &st_exp[14:13] || &st_exp[16:15] || &st_exp[10:9];
        end
    endfunction
    function [31:0] upd(input [1:0] op, input [31:0] o, input [31:0] v);
        upd = op == 2'h1 ? v : op == 2'h2 ? o | v : op == 2'h3 ? o & ~v : o;
    endfunction
    // Index 1 is never asked for: that view is not held here
    function [31:0] cnt_exp(input [7:0] n);
        reg [63:0] c;
        begin
            c = n[4:0] == 5'h0 ? cycle_count : n[4:0] == 5'h2 ? retired_count
                : perf_counts[(n[4:0] - 3) * 64 +: 64];
            cnt_exp = n[7] ? c[63:32] : c[31:0];
        end
    endfunction
    task check(input ok, input string msg);
        begin
            check_count = check_count + 1;
            if (!ok)
            begin
                num_errors = num_errors + 1;
                $display("mismatch at %0t: %0s", $time, msg);
            end
        end
    endtask
    task acc(input [11:0] a, input [1:0] op, input [31:0] v, input [31:0] e,
        input ill);
        begin
            @(posedge clk);
            csr_req <= 1'h1;
            csr_addr <= a;
            csr_op <= op;
            csr_operand <= v;
            @(posedge clk);
            csr_req <= 1'h0;
            #1;
            check(csr_valid === 1'h1 && csr_illegal === ill
                && csr_rdata === e, "access answer");
        end
    endtask
    task pulse(input t, input m);
        begin
            @(posedge clk);
            trap_enter <= t;
            machine_return <= m;
        end
    endtask
    task conclude;
        begin
            $display("checks %0d errors %0d", check_count, num_errors);
            if (num_errors == 0 && check_count > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    // ------------------------------------------
    // Main sequence
    // ------------------------------------------
    initial
    begin
        d = $urandom(32'hf4f8ad8e);
        repeat (8) @(posedge clk);
        resetn <= 1'h1;
        repeat (2) @(posedge clk);
        st = 32'h0;
        acc(12'h300, 2'h0, 32'h0, st_exp(st), 1'h0);
        for (i = 0; i < 12; i = i + 1)
        begin
            d = i == 0 ? 32'hffff_ffff : $urandom;
            acc(12'h300, i[1:0], d, st_exp(st), 1'h0);
            // Bit 7 ignores software writes
            st = upd(i[1:0], st, d) & 32'hffff_ff7f;
        end
        acc(12'h300, 2'h0, 32'h0, st_exp(st), 1'h0);
        acc(12'h300, 2'h1, st_exp(st), st_exp(st), 1'h0);
        acc(12'h300, 2'h0, 32'h0, st_exp(st), 1'h0);
        check(global_int_enable === st[3], "enable level");
        acc(12'h300, 2'h1, 32'h8, st_exp(st), 1'h0);
        pulse(1'h1, 1'h0);
        pulse(1'h0, 1'h0);
        acc(12'h300, 2'h0, 32'h0, st_exp(32'h80), 1'h0);
        check(global_int_enable === 1'h0, "enable after trap");
        pulse(1'h0, 1'h1);
        pulse(1'h0, 1'h0);
        acc(12'h300, 2'h0, 32'h0, st_exp(32'h88), 1'h0);
        check(global_int_enable === 1'h1, "enable after return");
        pulse(1'h1, 1'h0);
        pulse(1'h0, 1'h1);
        pulse(1'h0, 1'h0);
        acc(12'h300, 2'h0, 32'h0, st_exp(32'h88), 1'h0);
        // Writes one idle cycle apart: each read returns the previous stored base
        tj = 32'h0;
        for (i = 0; i < 6; i = i + 1)
        begin
            d = i == 0 ? 32'hffff_ffff : $urandom;
            acc(12'h017, 2'h1, d, tj, 1'h0);
            tj = d & 32'hffff_ffc0;
        end
        acc(12'h017, 2'h0, 32'h0, tj, 1'h0);
        check(table_jump_base === tj, "jump base output");
        @(posedge clk);
        cycle_count <= {$urandom, $urandom};
        retired_count <= {$urandom, $urandom};
        for (i = 0; i < 58; i = i + 1)
            perf_counts[i * 32 +: 32] <= $urandom;
        @(posedge clk);
        for (i = 0; i < 64; i = i + 1)
        begin
            d = i[4:0] == 5'h1 ? 32'h0 : cnt_exp({i[5], 2'h0, i[4:0]});
            acc({4'hc, i[5], 2'h0, i[4:0]}, 2'h0, 32'h0, d,
                i[4:0] == 5'h1);
            acc({4'hc, i[5], 2'h0, i[4:0]}, {i[0], 1'h1}, $urandom | 32'h1,
                32'h0, 1'h1);
        end
        acc(12'h7ff, 2'h0, 32'h0, 32'h0, 1'h1);
        acc(12'h301, 2'h1, 32'h0, 32'h0, 1'h1);
        conclude;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors = num_errors + 1;
        conclude;
    end
endmodule
